//--- src/approach_pkg.sv
/*
  Shared constants and types of the pulse width approach control block:
  register indices, field positions, reset values, codes, dividers.
  Assumes a byte-wide register port with a four-bit register index.
*/
package approach_pkg;

  // register indices on the register port
  localparam logic [3:0] IDX_TRIG_CFG = 4'h0;
  localparam logic [3:0] IDX_CHG_CFG = 4'h1;
  localparam logic [3:0] IDX_PRELOAD_A = 4'h2;
  localparam logic [3:0] IDX_PRELOAD_B = 4'h3;
  localparam logic [3:0] IDX_TARGET_C = 4'h4;
  localparam logic [3:0] IDX_TARGET_D = 4'h5;
  localparam logic [3:0] IDX_NINTH = 4'h6;
  localparam logic [3:0] IDX_PULSE_LIMIT = 4'h7;
  localparam logic [3:0] IDX_POLARITY = 4'h8;
  localparam logic [3:0] IDX_TMR_CTRL = 4'h9;
  localparam logic [3:0] IDX_TMR_ONE = 4'hA;
  localparam logic [3:0] IDX_TMR_TWO = 4'hB;
  localparam logic [3:0] IDX_TMR_THREE = 4'hC;
  localparam logic [3:0] IDX_TMR_READ = 4'hD;
  localparam logic [3:0] IDX_MODE = 4'hE;

  // field positions
  localparam int SRC_BIT = 7;
  localparam int M_LSB = 3;
  localparam int N_LSB = 0;
  localparam int TIMES_LSB = 4;
  localparam int MCHG_LSB = 2;
  localparam int NCHG_LSB = 0;
  localparam int NINTH_A_BIT = 0;
  localparam int NINTH_C_BIT = 2;
  localparam int NINTH_B_BIT = 4;
  localparam int NINTH_D_BIT = 6;
  localparam int TON_BIT = 4;
  localparam int PSC_LSB = 0;
  localparam int MODE_SEL_BIT = 6;
  localparam int PHASE_LSB = 2;

  // reset values and codes
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] OUTPUT_ACTIVE_HIGH = 8'h8D;
  localparam logic [10:0] PRESCALE_BASE = 11'h080;
  localparam logic [8:0] LIMIT_SPAN = 9'h100;

  typedef enum {PH_FLOAT_PRE, PH_TO_C, PH_TO_D, PH_FLOAT_POST} phase_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [8:0] preload_a;
    logic [8:0] preload_b;
    logic [1:0] trigger_times_m;
  } core_cfg_t;

endpackage

//--- src/approach_control.sv
/*
  Pulse width approach control: configuration registers, hardware
  approach of preload A toward targets C and D, interval timer with
  prescaler, pulse width limiter and output polarity gate.
  Assumes all inputs are synchronous to clock and that gen_pulse is
  the raw pulse of the generator core, whose clock equals clock.
*/
// Functional notes
// - timer trigger: comparator rise or enable bit
// - M field codes one to four triggers
// - N field step is value plus one
// - approach times field counts one to eight
// - M change: hold, hold, plus one, minus one
// - M at 00 or 11 stays fixed
// - M change direction reverses between C and D
// - no M change once A reached target
// - N change: hold, hold, plus one, minus one
// - N at 000 or 111 stays fixed
// - N change direction reverses between C and D
// - nine-bit values, ninth bits in shared register
// - main pulse capped at 256 minus limit, half clock
// - main output driven only at code 8D
// - secondary output low unless code 8D
// - enable writes ignored in comparator-triggered mode
// - prescaler divides by 128, 256, 512, 1024
// - three interval preloads reset to zero
// - unimplemented bits read zero, ignore writes
// - phase status reports four interval phases
// - mode rise clears enable, reloads from T1
// - ninth bit first, value applied on low byte
`timescale 1ns/100ps

module approach_control (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire approach_pkg::reg_req_t bus_req,
  output logic [7:0] rdata,
  // comparator and generator core
  input wire logic comparator_four_out,
  input wire logic gen_pulse,
  input wire logic secondary_pulse_in,
  // outputs
  output logic main_pulse_output,
  output logic main_pulse_oe,
  output logic secondary_pulse_output,
  output approach_pkg::core_cfg_t core_cfg
);

  logic [8:0] preload_a;
  logic [8:0] preload_b;
  logic [8:0] target_c;
  logic [8:0] target_d;
  logic [7:0] ninth_shadow;
  logic [7:0] pulse_limit_timer;
  logic [7:0] output_polarity_control;
  logic [7:0] interval_preload_one;
  logic [7:0] interval_preload_two;
  logic [7:0] interval_preload_three;
  logic [7:0] interval_count;
  logic hw_trigger_source_sel;
  logic [1:0] trigger_times_m;
  logic [2:0] approach_step_n;
  logic [2:0] approach_times_sel;
  logic [1:0] m_change_sel;
  logic [1:0] n_change_sel;
  logic interval_timer_enable;
  logic [1:0] interval_prescaler_sel;
  logic approach_mode_select;
  approach_pkg::phase_t phase;
  logic [2:0] approach_count;
  logic [9:0] prescale_count;
  logic cmp_q;
  logic pulse_q;
  logic half_tick;
  logic [8:0] limit_count;
  logic limited;

  logic wr_en;
  logic cmp_rise;
  logic pulse_rise;
  logic mode_rise;
  logic ton_writable;
  logic hw_start;
  logic tick;
  logic approaching;
  logic hw_op;
  logic change_due;
  logic reached;
  logic [8:0] target;
  logic [8:0] step;
  logic [8:0] next_a;
  logic [9:0] prescale_last;
  logic [1:0] phase_code;

  assign wr_en = bus_req.wr;
  assign cmp_rise = comparator_four_out && !cmp_q;
  assign pulse_rise = gen_pulse && !pulse_q;
  assign phase_code = 2'(phase);
  assign mode_rise = wr_en && bus_req.addr == approach_pkg::IDX_MODE &&
    bus_req.wdata[approach_pkg::MODE_SEL_BIT] && !approach_mode_select;
  assign ton_writable = !(approach_mode_select && !hw_trigger_source_sel);
  assign hw_start = approach_mode_select && !hw_trigger_source_sel &&
    cmp_rise && !interval_timer_enable;
  // divider of 128 shifted by the prescaler code
  assign prescale_last = 10'((approach_pkg::PRESCALE_BASE <<
    interval_prescaler_sel) - 11'h001);
  assign tick = interval_timer_enable && prescale_count == prescale_last;
  assign approaching = phase == approach_pkg::PH_TO_C ||
    phase == approach_pkg::PH_TO_D;
  assign hw_op = approach_mode_select && interval_timer_enable &&
    approaching && pulse_rise;
  assign change_due = hw_op && approach_count == approach_times_sel;
  assign target = phase == approach_pkg::PH_TO_D ? target_d : target_c;
  assign step = 9'({6'h00, approach_step_n}) + 9'h001;
  assign reached = preload_a == target;

  // next preload A, clamped at the target
  always_comb begin
    next_a = preload_a;
    if (preload_a < target) begin
      next_a = (target - preload_a <= step) ? target : preload_a + step;
    end else if (preload_a > target) begin
      next_a = (preload_a - target <= step) ? target : preload_a - step;
    end
  end

  // trigger source and change selections, software only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hw_trigger_source_sel <= 1'b0;
      approach_times_sel <= 3'h0;
      m_change_sel <= 2'h0;
      n_change_sel <= 2'h0;
    end else if (wr_en) begin
      if (bus_req.addr == approach_pkg::IDX_TRIG_CFG) begin
        hw_trigger_source_sel <= bus_req.wdata[approach_pkg::SRC_BIT];
      end
      if (bus_req.addr == approach_pkg::IDX_CHG_CFG) begin
        approach_times_sel <= bus_req.wdata[approach_pkg::TIMES_LSB +: 3];
        m_change_sel <= bus_req.wdata[approach_pkg::MCHG_LSB +: 2];
        n_change_sel <= bus_req.wdata[approach_pkg::NCHG_LSB +: 2];
      end
    end
  end

  // M and N: software writes, hardware changes per approach count
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      trigger_times_m <= 2'h0;
      approach_step_n <= 3'h0;
    end else if (wr_en && bus_req.addr == approach_pkg::IDX_TRIG_CFG) begin
      trigger_times_m <= bus_req.wdata[approach_pkg::M_LSB +: 2];
      approach_step_n <= bus_req.wdata[approach_pkg::N_LSB +: 3];
    end else if (change_due) begin
      if (m_change_sel[1] && !reached && trigger_times_m != 2'h0 &&
          trigger_times_m != 2'h3) begin
        if (m_change_sel[0] ^ (phase == approach_pkg::PH_TO_D)) begin
          trigger_times_m <= trigger_times_m - 2'h1;
        end else begin
          trigger_times_m <= trigger_times_m + 2'h1;
        end
      end
      if (n_change_sel[1] && approach_step_n != 3'h0 &&
          approach_step_n != 3'h7) begin
        if (n_change_sel[0] ^ (phase == approach_pkg::PH_TO_D)) begin
          approach_step_n <= approach_step_n - 3'h1;
        end else begin
          approach_step_n <= approach_step_n + 3'h1;
        end
      end
    end
  end

  // approach operations since the last change of M and N
  always_ff @(posedge clock) begin
    if (sys_rst || !approaching) begin
      approach_count <= 3'h0;
    end else if (change_due) begin
      approach_count <= 3'h0;
    end else if (hw_op) begin
      approach_count <= approach_count + 3'h1;
    end
  end

  // nine-bit values, ninth bits and pulse limit, no reset: undefined until written
  always_ff @(posedge clock) begin
    if (wr_en) begin
      unique case (bus_req.addr)
        approach_pkg::IDX_NINTH:
          ninth_shadow <= bus_req.wdata & 8'h55;
        approach_pkg::IDX_PRELOAD_B:
          preload_b <= {ninth_shadow[approach_pkg::NINTH_B_BIT],
            bus_req.wdata};
        approach_pkg::IDX_TARGET_C:
          target_c <= {ninth_shadow[approach_pkg::NINTH_C_BIT],
            bus_req.wdata};
        approach_pkg::IDX_TARGET_D:
          target_d <= {ninth_shadow[approach_pkg::NINTH_D_BIT],
            bus_req.wdata};
        approach_pkg::IDX_PULSE_LIMIT:
          pulse_limit_timer <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  // preload A: software commit on low byte, else hardware approach
  always_ff @(posedge clock) begin
    if (wr_en && bus_req.addr == approach_pkg::IDX_PRELOAD_A) begin
      preload_a <= {ninth_shadow[approach_pkg::NINTH_A_BIT],
        bus_req.wdata};
    end else if (hw_op) begin
      preload_a <= next_a;
    end
  end

  // polarity code and interval preloads
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      output_polarity_control <= approach_pkg::RESET_BYTE;
      interval_preload_one <= approach_pkg::RESET_BYTE;
      interval_preload_two <= approach_pkg::RESET_BYTE;
      interval_preload_three <= approach_pkg::RESET_BYTE;
      interval_prescaler_sel <= 2'h0;
      approach_mode_select <= 1'b0;
    end else if (wr_en) begin
      unique case (bus_req.addr)
        approach_pkg::IDX_POLARITY: output_polarity_control <= bus_req.wdata;
        approach_pkg::IDX_TMR_ONE: interval_preload_one <= bus_req.wdata;
        approach_pkg::IDX_TMR_TWO: interval_preload_two <= bus_req.wdata;
        approach_pkg::IDX_TMR_THREE: interval_preload_three <= bus_req.wdata;
        approach_pkg::IDX_TMR_CTRL:
          interval_prescaler_sel <= bus_req.wdata[approach_pkg::PSC_LSB +: 2];
        approach_pkg::IDX_MODE:
          approach_mode_select <= bus_req.wdata[approach_pkg::MODE_SEL_BIT];
        default: ;
      endcase
    end
  end

  // interval timer: enable, count and phase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      interval_timer_enable <= 1'b0;
      interval_count <= approach_pkg::RESET_BYTE;
      phase <= approach_pkg::PH_FLOAT_PRE;
    end else if (mode_rise) begin
      interval_timer_enable <= 1'b0;
      interval_count <= interval_preload_one;
      phase <= approach_pkg::PH_FLOAT_PRE;
    end else if (hw_start) begin
      interval_timer_enable <= 1'b1;
      interval_count <= interval_preload_one;
      phase <= approach_pkg::PH_FLOAT_PRE;
    end else if (wr_en && bus_req.addr == approach_pkg::IDX_TMR_CTRL &&
        ton_writable) begin
      interval_timer_enable <= bus_req.wdata[approach_pkg::TON_BIT];
      if (bus_req.wdata[approach_pkg::TON_BIT] && !interval_timer_enable) begin
        interval_count <= interval_preload_one;
        phase <= approach_pkg::PH_FLOAT_PRE;
      end
    end else if (tick) begin
      if (interval_count == 8'hFF) begin
        unique case (phase)
          approach_pkg::PH_FLOAT_PRE: begin
            phase <= approach_pkg::PH_TO_C;
            interval_count <= interval_preload_two;
          end
          approach_pkg::PH_TO_C: begin
            phase <= approach_pkg::PH_TO_D;
            interval_count <= interval_preload_three;
          end
          approach_pkg::PH_TO_D: begin
            phase <= approach_pkg::PH_FLOAT_POST;
            interval_count <= interval_preload_one;
          end
          approach_pkg::PH_FLOAT_POST: begin
            // cycle ends, wait for the next trigger
            phase <= approach_pkg::PH_FLOAT_PRE;
            interval_timer_enable <= 1'b0;
            interval_count <= interval_preload_one;
          end
        endcase
      end else begin
        interval_count <= interval_count + 8'h01;
      end
    end
  end

  // prescaler of the interval timer
  always_ff @(posedge clock) begin
    if (sys_rst || !interval_timer_enable || tick) begin
      prescale_count <= 10'h000;
    end else begin
      prescale_count <= prescale_count + 10'h001;
    end
  end

  // input edge registers and half-rate enable of the generator clock
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmp_q <= 1'b0;
      pulse_q <= 1'b0;
      half_tick <= 1'b0;
    end else begin
      cmp_q <= comparator_four_out;
      pulse_q <= gen_pulse;
      half_tick <= !half_tick;
    end
  end

  // pulse width limiter counts from the limit value up to 256
  always_ff @(posedge clock) begin
    if (sys_rst || !gen_pulse) begin
      limited <= 1'b0;
      limit_count <= {1'b0, pulse_limit_timer};
    end else if (!limited && half_tick) begin
      limit_count <= limit_count + 9'h001;
      if (limit_count + 9'h001 == approach_pkg::LIMIT_SPAN) begin
        limited <= 1'b1;
      end
    end
  end

  // output gates
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      main_pulse_output <= 1'b0;
      main_pulse_oe <= 1'b0;
      secondary_pulse_output <= 1'b0;
    end else begin
      main_pulse_oe <= output_polarity_control ==
        approach_pkg::OUTPUT_ACTIVE_HIGH;
      main_pulse_output <= gen_pulse && !limited;
      secondary_pulse_output <= secondary_pulse_in &&
        output_polarity_control == approach_pkg::OUTPUT_ACTIVE_HIGH;
    end
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge clock) begin
    if (sys_rst || !bus_req.rd) begin
      rdata <= approach_pkg::RESET_BYTE;
    end else begin
      unique case (bus_req.addr)
        approach_pkg::IDX_TRIG_CFG:
          rdata <= {hw_trigger_source_sel, 2'b00, trigger_times_m,
            approach_step_n};
        approach_pkg::IDX_CHG_CFG:
          rdata <= {1'b0, approach_times_sel, m_change_sel, n_change_sel};
        approach_pkg::IDX_PRELOAD_A: rdata <= preload_a[7:0];
        approach_pkg::IDX_PRELOAD_B: rdata <= preload_b[7:0];
        approach_pkg::IDX_TARGET_C: rdata <= target_c[7:0];
        approach_pkg::IDX_TARGET_D: rdata <= target_d[7:0];
        approach_pkg::IDX_NINTH: rdata <= ninth_shadow;
        approach_pkg::IDX_PULSE_LIMIT: rdata <= pulse_limit_timer;
        approach_pkg::IDX_POLARITY: rdata <= output_polarity_control;
        approach_pkg::IDX_TMR_CTRL:
          rdata <= {3'b000, interval_timer_enable, 2'b00,
            interval_prescaler_sel};
        approach_pkg::IDX_TMR_ONE: rdata <= interval_preload_one;
        approach_pkg::IDX_TMR_TWO: rdata <= interval_preload_two;
        approach_pkg::IDX_TMR_THREE: rdata <= interval_preload_three;
        approach_pkg::IDX_TMR_READ: rdata <= interval_count;
        approach_pkg::IDX_MODE:
          rdata <= {1'b0, approach_mode_select, 2'b00, phase_code,
            2'b00};
        default: rdata <= approach_pkg::RESET_BYTE;
      endcase
    end
  end

  assign core_cfg.preload_a = preload_a;
  assign core_cfg.preload_b = preload_b;
  assign core_cfg.trigger_times_m = trigger_times_m;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_trigger_start: assert property (
    hw_start && !mode_rise |=> interval_timer_enable &&
      interval_count == $past(interval_preload_one))
    else $error("comparator rise did not start interval timer");

  a_ton_ignored: assert property (
    wr_en && bus_req.addr == approach_pkg::IDX_TMR_CTRL &&
      approach_mode_select && !hw_trigger_source_sel && !cmp_rise &&
      !tick && !mode_rise |=> $stable(interval_timer_enable))
    else $error("enable write took effect in comparator mode");

  a_mode_rise: assert property (
    mode_rise |=> !interval_timer_enable &&
      interval_count == $past(interval_preload_one) &&
      approach_mode_select)
    else $error("mode rise did not reload timer");

  a_no_overshoot: assert property (
    hw_op && !(wr_en && bus_req.addr == approach_pkg::IDX_PRELOAD_A) &&
      preload_a < target |=> preload_a <= $past(target) &&
      preload_a > $past(preload_a))
    else $error("preload A overshot its target");

  a_m_fixed_ends: assert property (
    (trigger_times_m == 2'h0 || trigger_times_m == 2'h3) &&
      !(wr_en && bus_req.addr == approach_pkg::IDX_TRIG_CFG)
      |=> $stable(trigger_times_m))
    else $error("M left a fixed end value");

  a_m_step_up: assert property (
    change_due && m_change_sel == 2'b10 && phase == approach_pkg::PH_TO_C &&
      trigger_times_m == 2'h1 && !reached &&
      !(wr_en && bus_req.addr == approach_pkg::IDX_TRIG_CFG)
      |=> trigger_times_m == 2'h2)
    else $error("M did not increase toward C");

  a_n_fixed_ends: assert property (
    (approach_step_n == 3'h0 || approach_step_n == 3'h7) &&
      !(wr_en && bus_req.addr == approach_pkg::IDX_TRIG_CFG)
      |=> $stable(approach_step_n))
    else $error("N left a fixed end value");

  a_low_byte_commit: assert property (
    wr_en && bus_req.addr == approach_pkg::IDX_PRELOAD_A |=>
      preload_a == {$past(ninth_shadow[approach_pkg::NINTH_A_BIT]),
        $past(bus_req.wdata)})
    else $error("preload A commit wrong");

  a_pulse_cut: assert property (
    limited && gen_pulse |=> !main_pulse_output)
    else $error("pulse passed beyond its width limit");

  a_float_output: assert property (
    output_polarity_control != approach_pkg::OUTPUT_ACTIVE_HIGH |=>
      !main_pulse_oe)
    else $error("main output driven with wrong code");

  a_secondary_low: assert property (
    output_polarity_control != approach_pkg::OUTPUT_ACTIVE_HIGH |=>
      !secondary_pulse_output)
    else $error("secondary output not held low");

  a_readback_count: assert property (
    bus_req.rd && bus_req.addr == approach_pkg::IDX_TMR_READ |=>
      rdata == $past(interval_count))
    else $error("count readback wrong");

  a_phase_report: assert property (
    bus_req.rd && bus_req.addr == approach_pkg::IDX_MODE |=>
      rdata[approach_pkg::PHASE_LSB +: 2] == $past(phase_code))
    else $error("phase status wrong");

  a_reset_preload: assert property (
    disable iff (1'b0) $past(sys_rst) |-> interval_preload_one == 8'h00 &&
      interval_preload_three == 8'h00)
    else $error("interval preload not cleared by reset");

  c_hw_start: cover property (hw_start);
  c_approach_change: cover property (change_due && !reached);
  c_pulse_limited: cover property (limited && gen_pulse);
  c_phase_post: cover property (phase == approach_pkg::PH_FLOAT_POST);

endmodule // approach_control

//--- sim/approach_partner.sv
/*
  Far-side model: comparator four output and generator core pulses.
  Assumes one-cycle go strobes from the bench, synchronous to clock.
*/
`timescale 1ns/100ps
module approach_partner (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // commands
  input wire logic pulse_go,
  input wire logic [7:0] pulse_len,
  input wire logic cmp_go,
  // toward the block
  output logic gen_pulse,
  output logic secondary_pulse_in,
  output logic comparator_four_out
);
  logic [7:0] cnt;
  logic [2:0] cmp_cnt;
  assign secondary_pulse_in = gen_pulse;
  assign comparator_four_out = (cmp_cnt != 3'h0);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt <= 8'h00;
      gen_pulse <= 1'b0;
    end else if (pulse_go) begin
      cnt <= pulse_len;
      gen_pulse <= 1'b1;
    end else if (cnt > 8'h01) begin
      cnt <= cnt - 8'h01;
    end else begin
      cnt <= 8'h00;
      gen_pulse <= 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) cmp_cnt <= 3'h0;
    else if (cmp_go) cmp_cnt <= 3'h4;
    else if (cmp_cnt != 3'h0) cmp_cnt <= cmp_cnt - 3'h1;
  end
endmodule // approach_partner

//--- sim/pulse_width_approach_control_tb.sv
/*
  Self-checking bench of the approach control block.
  Assumes the register port contract: read data one cycle after rd.
*/
`timescale 1ns/100ps
module pulse_width_approach_control_tb;
  localparam logic [3:0] M_IDX[5] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'hF};
  localparam logic [7:0] M_VAL[5] = '{8'h9F, 8'h7F, 8'h55, 8'hFF, 8'h00};
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  approach_pkg::reg_req_t bus_req = '0;
  logic [7:0] rdata;
  logic comparator_four_out;
  logic gen_pulse;
  logic secondary_pulse_in;
  logic main_pulse_output;
  logic main_pulse_oe;
  logic secondary_pulse_output;
  approach_pkg::core_cfg_t core_cfg;
  logic pulse_go = 1'b0;
  logic cmp_go = 1'b0;
  logic [7:0] pulse_len = 8'h00;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'd97630;
  logic [7:0] v;
  int hi;
  int errors = 0;
  int tests_run = 0;

  always #5 clock = ~clock;

  approach_control dut (.clock(clock), .sys_rst(sys_rst),
    .bus_req(bus_req), .rdata(rdata),
    .comparator_four_out(comparator_four_out), .gen_pulse(gen_pulse),
    .secondary_pulse_in(secondary_pulse_in),
    .main_pulse_output(main_pulse_output), .main_pulse_oe(main_pulse_oe),
    .secondary_pulse_output(secondary_pulse_output), .core_cfg(core_cfg));

  approach_partner partner (.clock(clock), .sys_rst(sys_rst),
    .pulse_go(pulse_go), .pulse_len(pulse_len), .cmp_go(cmp_go),
    .gen_pulse(gen_pulse), .secondary_pulse_in(secondary_pulse_in),
    .comparator_four_out(comparator_four_out));

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    exp_q.push_back(e);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req <= '0;
  endtask

  task automatic pulse(input logic [7:0] len, input int wait_n);
    @(posedge clock);
    pulse_go <= 1'b1;
    pulse_len <= len;
    @(posedge clock);
    pulse_go <= 1'b0;
    repeat (wait_n) @(posedge clock);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_seen) check({1'b0, rdata}, {1'b0, exp_q.pop_front()});
    rd_seen <= bus_req.rd;
  end

  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    results();
  end

  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 16; i++)
      if (i < 2 || i > 7) rd(i[3:0], 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 5; i++) begin
      wr(M_IDX[i], 8'hFF);
      rd(M_IDX[i], M_VAL[i]);
    end
    for (int i = 10; i < 13; i++) begin
      v = rnd();
      wr(i[3:0], v);
      rd(i[3:0], v);
    end
    wr(4'hD, 8'hFF);
    rd(4'hD, 8'h00);
    wr(4'h9, 8'hFF);
    rd(4'h9, 8'h13);
    wr(4'h9, 8'h00);
    $display("test field masks done");
    wr(4'h6, 8'h01);
    v = rnd();
    wr(4'h2, v);
    @(negedge clock);
    check(core_cfg.preload_a, {1'b1, v});
    wr(4'h6, 8'h10);
    @(negedge clock);
    check(core_cfg.preload_a, {1'b1, v});
    wr(4'h3, ~v);
    @(negedge clock);
    check(core_cfg.preload_b, {1'b1, ~v});
    $display("test ninth bits done");
    wr(4'h8, 8'h55);
    pulse(8'd10, 3);
    check(main_pulse_oe, 1'b0);
    check(secondary_pulse_output, 1'b0);
    wr(4'h8, 8'h8D);
    pulse(8'd10, 3);
    check(main_pulse_oe, 1'b1);
    check(secondary_pulse_output, 1'b1);
    repeat (10) @(posedge clock);
    wr(4'h7, 8'hFC);
    hi = 0;
    pulse(8'd40, 0);
    repeat (50) begin
      @(posedge clock);
      if (main_pulse_output === 1'b1) hi++;
    end
    check(hi >= 7 && hi <= 9, 1'b1);
    $display("test output and limiter done");
    wr(4'hA, 8'hFE);
    wr(4'hB, 8'h00);
    wr(4'h0, 8'h0B);
    wr(4'h1, 8'h1A);
    wr(4'h6, 8'h05);
    wr(4'h4, 8'h0A);
    wr(4'h2, 8'h00);
    wr(4'h9, 8'h10);
    wr(4'hE, 8'h40);
    rd(4'h9, 8'h00);
    wr(4'h9, 8'h10);
    rd(4'h9, 8'h00);
    @(posedge clock);
    cmp_go <= 1'b1;
    @(posedge clock);
    cmp_go <= 1'b0;
    repeat (3) @(posedge clock);
    rd(4'h9, 8'h10);
    repeat (150) @(posedge clock);
    rd(4'hD, 8'hFF);
    repeat (110) @(posedge clock);
    rd(4'hE, 8'h44);
    repeat (4) pulse(8'd3, 6);
    check(core_cfg.preload_a, 9'h10A);
    check(core_cfg.trigger_times_m, 2'h2);
    rd(4'h0, 8'h15);
    repeat (3) @(posedge clock);
    $display("test hardware approach done");
    results();
  end
endmodule // pulse_width_approach_control_tb
